/* logic/fpv_consts.vh */
/*
 Constants for the flat panel video port: timing counts, defaults,
 multipurpose pin modes, overlay key modes and power sequence states.
 Assumes a 125 MHz system clock that also serves as the dot clock.
*/
`ifndef FPV_CONSTS_VH
`define FPV_CONSTS_VH

`define FPV_CLK_MHZ        125
`define FPV_SEQ_STEP_US    10
`define FPV_SEQ_STEP_CYC   (`FPV_SEQ_STEP_US * `FPV_CLK_MHZ)

`define FPV_H_ACTIVE_DEF   12'h280
`define FPV_H_TOTAL_DEF    12'h320
`define FPV_V_ACTIVE_DEF   12'h1e0
`define FPV_V_TOTAL_DEF    12'h20d

`define FPV_MP_AC_DRIVE    2'h0
`define FPV_MP_BLANK_N     2'h1
`define FPV_MP_DISP_EN     2'h2

`define FPV_KEY_COLOR      1'h0
`define FPV_KEY_WINDOW     1'h1

`define FPV_PM_ON          2'h0
`define FPV_PM_PANEL_OFF   2'h1
`define FPV_PM_STANDBY     2'h2

`define FPV_SEQ_OFF        3'h0
`define FPV_SEQ_LOGIC      3'h1
`define FPV_SEQ_SIGNALS    3'h2
`define FPV_SEQ_BIAS       3'h3
`define FPV_SEQ_ON         3'h4

`endif

/* logic/fpv_video_port.v */
/*
 Flat panel video port: panel timing, pixel bus, power sequencing with
 power modes, and zoomed-video overlay input.
 Assumes clk is the dot clock; control bits arrive on clk from local
 logic; zoomed-video pins arrive asynchronously and are synchronised.
*/
// Functional notes
// - Drive panel shift clock qualifying pixel words.
// - Multipurpose pin: AC toggle, blank, enable.
// - One line latch pulse per display line.
// - First line marker at each frame start.
// - 36-bit pixel bus in two ordered groups.
// - Active-high panel logic supply enable.
// - Active-high panel bias supply enable.
// - Active-high backlight power enable.
// - Panel power only via three enables.
// - Power modes reuse the sequencing enables.
// - Panel-off mode blanks panel and CRT.
// - Standby also stops graphics, DRAM self-refresh.
// - Accept RGB or YUV parallel video samples.
// - Video clock is half or quarter of dot clock.
// - Scale, position, overlay incoming video.
// - Color key or X-Y window keying.
// - Disable setting turns whole controller off.
`timescale 1ns/1ns
`include "fpv_consts.vh"

module fpv_video_port
#(
   parameter SEQ_STEP_CYC = `FPV_SEQ_STEP_CYC
)
(
   input  wire        clk,
   input  wire        rst,
   input  wire        ctrl_enable,
   input  wire [1:0]  power_mode,
   input  wire [1:0]  mp_mode,
   input  wire [11:0] h_active,
   input  wire [11:0] h_total,
   input  wire [11:0] v_active,
   input  wire [11:0] v_total,
   input  wire [35:0] gfx_pixel,
   input  wire        zv_enable,
   input  wire        zv_yuv_mode,
   input  wire        zv_clk_half,
   input  wire        zv_key_mode,
   input  wire [15:0] zv_color_key,
   input  wire [11:0] zv_x_start,
   input  wire [11:0] zv_y_start,
   input  wire [11:0] zv_x_end,
   input  wire [11:0] zv_y_end,
   input  wire        zv_x2,
   input  wire        zv_y2,
   input  wire [15:0] zv_video_data,
   input  wire        zv_vertical_reference,
   input  wire        zv_horizontal_reference,
   output reg         panel_shift_clock,
   output reg         ac_drive_or_display_enable,
   output reg         line_latch_pulse,
   output reg         frame_first_line_marker,
   output reg  [23:0] panel_pixel_low_group,
   output reg  [11:0] panel_pixel_high_group,
   output reg         panel_logic_power_en,
   output reg         panel_bias_power_en,
   output reg         backlight_power_en,
   output reg         crt_output_en,
   output reg         graphics_run,
   output reg         dram_self_refresh,
   output reg         zv_pixel_clock,
   output reg         gfx_x_req_ff,
   output reg  [11:0] gfx_y_pos
);

   ////////////////////////////////////////////////////////////////////////
   // Power modes and sequencing.

   reg [2:0]  seq_ff;
   reg [2:0]  nxt_seq;
   reg [31:0] step_cnt_ff;
   reg        want_on;
   reg        step_done;

   always @*
   begin
      // Panel-off and standby both run the power-down sequence.
      want_on = ctrl_enable && (power_mode == `FPV_PM_ON);
      step_done = (step_cnt_ff == (SEQ_STEP_CYC - 1));
      nxt_seq = seq_ff;
      if (step_done)
      begin
         if (want_on && (seq_ff != `FPV_SEQ_ON))
            nxt_seq = seq_ff + 3'h1;
         else if (!want_on && (seq_ff != `FPV_SEQ_OFF))
            nxt_seq = seq_ff - 3'h1;
      end
   end

   always @(posedge clk)
   begin
      if (rst)
      begin
         seq_ff <= `FPV_SEQ_OFF;
         step_cnt_ff <= 32'h0;
         panel_logic_power_en <= 1'b0;
         panel_bias_power_en <= 1'b0;
         backlight_power_en <= 1'b0;
         crt_output_en <= 1'b0;
         graphics_run <= 1'b0;
         dram_self_refresh <= 1'b0;
      end
      else
      begin
         seq_ff <= nxt_seq;
         if (step_done || (want_on ? seq_ff == `FPV_SEQ_ON : seq_ff == `FPV_SEQ_OFF))
            step_cnt_ff <= 32'h0;
         else
            step_cnt_ff <= step_cnt_ff + 32'h1;
         // Supplies reach the panel only through these three enables.
         panel_logic_power_en <= (nxt_seq >= `FPV_SEQ_LOGIC);
         panel_bias_power_en <= (nxt_seq >= `FPV_SEQ_BIAS);
         backlight_power_en <= (nxt_seq == `FPV_SEQ_ON);
         crt_output_en <= want_on;
         graphics_run <= ctrl_enable && (power_mode != `FPV_PM_STANDBY);
         dram_self_refresh <= !ctrl_enable || (power_mode == `FPV_PM_STANDBY);
      end
   end

   wire signals_on = (seq_ff >= `FPV_SEQ_SIGNALS);

   ////////////////////////////////////////////////////////////////////////
   // Panel timing; one pixel per two dot clocks, shift clock at half rate.

   reg        phase_ff;
   reg [11:0] h_ff;
   reg [11:0] v_ff;
   reg        ac_ff;

   wire h_last = (h_ff >= h_total - 12'h1);
   wire v_last = (v_ff >= v_total - 12'h1);
   wire active = (h_ff < h_active) && (v_ff < v_active);

   always @(posedge clk)
   begin
      if (rst || !signals_on)
      begin
         phase_ff <= 1'b0;
         h_ff <= 12'h0;
         v_ff <= 12'h0;
         ac_ff <= 1'b0;
      end
      else
      begin
         // Counters step once per shift clock period.
         phase_ff <= ~phase_ff;
         if (phase_ff)
         begin
            h_ff <= h_last ? 12'h0 : h_ff + 12'h1;
            if (h_last)
            begin
               v_ff <= v_last ? 12'h0 : v_ff + 12'h1;
               if (v_last)
                  ac_ff <= ~ac_ff;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Zoomed-video input: three-stage synchronisers on all pins.

   reg [17:0] zv_s1_ff;
   reg [17:0] zv_s2_ff;
   reg [17:0] zv_s3_ff;
   reg [17:0] zv_hold_ff;
   reg        zv_div_ff;

   genvar i;
   generate
      for (i = 0; i < 18; i = i + 1)
      begin : g_zv_sync
         always @(posedge clk)
         begin
            if (rst)
            begin
               zv_s1_ff[i] <= 1'b0;
               zv_s2_ff[i] <= 1'b0;
               zv_s3_ff[i] <= 1'b0;
               zv_hold_ff[i] <= 1'b0;
            end
            else
            begin
               zv_s1_ff[i] <= (i < 16) ? zv_video_data[i % 16]
                            : (i == 16) ? zv_horizontal_reference
                            : zv_vertical_reference;
               zv_s2_ff[i] <= zv_s1_ff[i];
               zv_s3_ff[i] <= zv_s2_ff[i];
               if (zv_s2_ff[i] == zv_s3_ff[i])
                  zv_hold_ff[i] <= zv_s3_ff[i];
            end
         end
      end
   endgenerate

   // The sample line buffer is a flip-flop array indexed by column.
   reg [15:0] zv_line [0:63];
   reg [5:0]  zv_wr_ff;
   reg        zv_zv_horizontal_reference_d_ff;
   reg [11:0] zv_row_ff;

   always @(posedge clk)
   begin
      if (rst)
      begin
         zv_div_ff <= 1'b0;
         zv_pixel_clock <= 1'b0;
         zv_wr_ff <= 6'h0;
         zv_zv_horizontal_reference_d_ff <= 1'b0;
         zv_row_ff <= 12'h0;
      end
      else
      begin
         zv_div_ff <= ~zv_div_ff;
         // A registered pin toggles at most once a cycle, so full rate is half the
         // clock and the divided rate toggles only on every other cycle.
         if (!(ctrl_enable && zv_enable))
            zv_pixel_clock <= 1'b0;
         else if (!zv_clk_half || zv_div_ff)
            zv_pixel_clock <= ~zv_pixel_clock;
         zv_zv_horizontal_reference_d_ff <= zv_hold_ff[16];
         if (zv_hold_ff[17])
            zv_row_ff <= 12'h0;
         else if (zv_zv_horizontal_reference_d_ff && !zv_hold_ff[16])
            zv_row_ff <= zv_row_ff + 12'h1;
         if (!zv_hold_ff[16])
            zv_wr_ff <= 6'h0;
         else if ((!zv_clk_half || zv_div_ff) && !zv_pixel_clock)
         begin
            // One sample per video clock period, taken as that clock rises.
            zv_line[zv_wr_ff] <= zv_hold_ff[15:0];
            zv_wr_ff <= zv_wr_ff + 6'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Overlay: position, integer zoom and key selection.

   reg [11:0] rel_x;
   reg [11:0] rel_y;
   reg [15:0] zv_sample;
   reg [35:0] zv_rgb;
   reg        in_win;
   reg        use_zv;
   reg [35:0] pix_out;

   always @*
   begin
      rel_x = h_ff - zv_x_start;
      rel_y = v_ff - zv_y_start;
      zv_sample = zv_line[zv_x2 ? rel_x[6:1] : rel_x[5:0]];
      // YUV samples are shown as luminance grey.
      if (zv_yuv_mode)
         zv_rgb = {3{zv_sample[15:8], 4'h0}};
      else
         zv_rgb = {zv_sample[15:11], 7'h0, zv_sample[10:5], 6'h0,
                   zv_sample[4:0], 7'h0};
      in_win = (h_ff >= zv_x_start) && (h_ff < zv_x_end) &&
               (v_ff >= zv_y_start) && (v_ff < zv_y_end) &&
               ((zv_y2 ? rel_y[11:1] : rel_y[11:0]) <= {1'b0, zv_row_ff[10:0]});
      if (zv_key_mode == `FPV_KEY_WINDOW)
         use_zv = zv_enable && in_win;
      else
         use_zv = zv_enable && in_win &&
                  (gfx_pixel[15:0] == zv_color_key);
      pix_out = use_zv ? zv_rgb : gfx_pixel;
   end

   ////////////////////////////////////////////////////////////////////////
   // Panel pins, all registered.

   always @(posedge clk)
   begin
      // Pins run until the sequence drops below the signal step, so power-down
      // stops them only after bias and backlight are off.
      if (rst || !signals_on)
      begin
         panel_shift_clock <= 1'b0;
         ac_drive_or_display_enable <= 1'b0;
         line_latch_pulse <= 1'b0;
         frame_first_line_marker <= 1'b0;
         panel_pixel_low_group <= 24'h0;
         panel_pixel_high_group <= 12'h0;
         gfx_x_req_ff <= 1'b0;
         gfx_y_pos <= 12'h0;
      end
      else
      begin
         // Data changes on the falling edge; panel samples on rising.
         panel_shift_clock <= phase_ff;
         line_latch_pulse <= (h_ff == h_active) && (v_ff < v_active);
         frame_first_line_marker <= (v_ff == 12'h0) && (h_ff == h_active);
         case (mp_mode)
            `FPV_MP_AC_DRIVE: ac_drive_or_display_enable <= ac_ff;
            `FPV_MP_BLANK_N:  ac_drive_or_display_enable <= active;
            `FPV_MP_DISP_EN:  ac_drive_or_display_enable <= active;
            default:          ac_drive_or_display_enable <= ac_ff;
         endcase
         if (!phase_ff)
         begin
            panel_pixel_low_group <= active ? pix_out[23:0] : 24'h0;
            panel_pixel_high_group <= active ? pix_out[35:24] : 12'h0;
         end
         gfx_x_req_ff <= active && !phase_ff;
         gfx_y_pos <= v_ff;
      end
   end

endmodule

/* sim/fpv_video_port_sva.sv */
/*
 Checker for the flat panel video port: pulses, power order, power modes.
 Assumes it is bound into fpv_video_port and shares its sequence step.
*/
`timescale 1ns/1ns
`include "fpv_consts.vh"
module fpv_video_port_sva
#(
   parameter SEQ_STEP_CYC = 4
)
(
   input wire        clk,
   input wire        rst,
   input wire        ctrl_enable,
   input wire [1:0]  power_mode,
   input wire        panel_shift_clock,
   input wire        line_latch_pulse,
   input wire        frame_first_line_marker,
   input wire [23:0] panel_pixel_low_group,
   input wire        panel_logic_power_en,
   input wire        panel_bias_power_en,
   input wire        backlight_power_en,
   input wire        crt_output_en,
   input wire        graphics_run,
   input wire        dram_self_refresh
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence one_more_then_low(s);
      s ##1 !s;
   endsequence
   // Cycles spent outside on mode; the whole power-down walk fits in four steps.
   reg [15:0] off_cnt_ff;
   always @(posedge clk)
   begin
      if (rst || power_mode == `FPV_PM_ON)
         off_cnt_ff <= 16'h0;
      else if (off_cnt_ff != 16'hffff)
         off_cnt_ff <= off_cnt_ff + 16'h1;
   end
   chk_shift_half_rate: assert property ($rose(panel_shift_clock) |=> $fell(panel_shift_clock))
      else $error("shift clock high phase not one cycle");
   chk_latch_width: assert property ($rose(line_latch_pulse) |=> one_more_then_low(line_latch_pulse))
      else $error("line latch pulse width wrong");
   chk_marker_width: assert property ($rose(frame_first_line_marker)
      |=> one_more_then_low(frame_first_line_marker))
      else $error("first line marker width wrong");
   chk_bias_needs_logic: assert property (panel_bias_power_en |-> panel_logic_power_en)
      else $error("bias enabled without logic supply");
   chk_light_needs_bias: assert property (backlight_power_en |-> panel_bias_power_en)
      else $error("backlight enabled without bias");
   chk_logic_leads_bias: assert property ($rose(panel_bias_power_en)
      |-> $past(panel_logic_power_en, SEQ_STEP_CYC))
      else $error("logic supply did not lead bias");
   chk_pins_quiet_off: assert property (off_cnt_ff >= 4 * SEQ_STEP_CYC
      |-> !panel_shift_clock && panel_pixel_low_group == 24'h0)
      else $error("panel pins active outside on mode");
   chk_panel_off_mode: assert property ((ctrl_enable && power_mode == `FPV_PM_PANEL_OFF)[*4]
      |-> graphics_run && !dram_self_refresh && !crt_output_en)
      else $error("panel off mode outputs wrong");
   chk_standby_mode: assert property ((power_mode == `FPV_PM_STANDBY)[*4]
      |-> dram_self_refresh && !graphics_run && !crt_output_en)
      else $error("standby mode outputs wrong");
   chk_disable_all: assert property ((!ctrl_enable)[*4] |-> dram_self_refresh && !graphics_run)
      else $error("disabled controller still running");
endmodule
bind fpv_video_port fpv_video_port_sva #(.SEQ_STEP_CYC(SEQ_STEP_CYC)) fpv_video_port_sva_inst
   (.clk, .rst, .ctrl_enable, .power_mode, .panel_shift_clock, .line_latch_pulse,
    .frame_first_line_marker, .panel_pixel_low_group, .panel_logic_power_en,
    .panel_bias_power_en, .backlight_power_en, .crt_output_en, .graphics_run,
    .dram_self_refresh);

/* sim/fpv_zv_source.sv */
/*
 Model of the external zoomed-video source.
 Assumes it is clocked by the port's video clock output.
*/
`timescale 1ns/1ns
module fpv_zv_source
(
   input  wire        zv_pixel_clock,
   output reg  [15:0] zv_video_data,
   output reg         zv_vertical_reference,
   output reg         zv_horizontal_reference
);
   reg [7:0] pos_ff = 8'h0;
   initial
   begin
      zv_video_data = 16'h0;
      zv_vertical_reference = 1'b0;
      zv_horizontal_reference = 1'b0;
   end
   // Outside a line the data is not held, so a stale sample cannot pass as valid.
   always @(posedge zv_pixel_clock)
   begin
      pos_ff <= pos_ff + 8'h1;
      zv_vertical_reference <= (pos_ff[7:5] == 3'h0);
      zv_horizontal_reference <= !pos_ff[4];
      zv_video_data <= !pos_ff[4] ? {pos_ff, 8'h5a} : ~zv_video_data;
   end
endmodule

/* sim/flat_panel_video_port_tb.sv */
/*
 Self-checking bench for the flat panel video port with a video source model.
 Assumes the design, its constants header and the checker are compiled first.
*/
`timescale 1ns/1ns
`include "fpv_consts.vh"
module flat_panel_video_port_tb;
   reg clk, rst, ctrl_enable, zv_enable, zv_yuv_mode, zv_clk_half, zv_key_mode, zv_x2, zv_y2;
   reg [1:0] power_mode, mp_mode;
   reg [11:0] h_active, h_total, v_active, v_total;
   reg [35:0] gfx_pixel;
   wire [15:0] zv_video_data;
   wire zv_vertical_reference, zv_horizontal_reference, panel_shift_clock, line_latch_pulse;
   wire ac_drive_or_display_enable, frame_first_line_marker, panel_logic_power_en;
   wire panel_bias_power_en, backlight_power_en, crt_output_en, graphics_run;
   wire dram_self_refresh, zv_pixel_clock, gfx_x_req_ff;
   wire [23:0] panel_pixel_low_group;
   wire [11:0] panel_pixel_high_group, gfx_y_pos;
   integer err_count, num_checks, i, k, n_hi, n_lo, n_lp, n_fm, n_px, n_bad, n_zc, z_full;
   reg zc_prev, lp_prev;
   reg [15:0] zv_color_key;
   fpv_video_port #(.SEQ_STEP_CYC(4)) fpv_video_port_inst (.clk, .rst, .ctrl_enable, .power_mode,
      .mp_mode, .h_active, .h_total, .v_active, .v_total, .gfx_pixel, .zv_enable, .zv_yuv_mode,
      .zv_clk_half, .zv_key_mode, .zv_color_key, .zv_x_start(12'h000),
      .zv_y_start(12'h000), .zv_x_end(h_active >> 1), .zv_y_end(v_active), .zv_x2, .zv_y2,
      .zv_video_data, .zv_vertical_reference, .zv_horizontal_reference, .panel_shift_clock,
      .ac_drive_or_display_enable, .line_latch_pulse, .frame_first_line_marker,
      .panel_pixel_low_group, .panel_pixel_high_group, .panel_logic_power_en,
      .panel_bias_power_en, .backlight_power_en, .crt_output_en, .graphics_run,
      .dram_self_refresh, .zv_pixel_clock, .gfx_x_req_ff, .gfx_y_pos);
   fpv_zv_source fpv_zv_source_inst (.zv_pixel_clock, .zv_video_data, .zv_vertical_reference,
      .zv_horizontal_reference);
   always #4 clk = ~clk;
   task tick(input integer n);
   begin
      repeat (n) @(posedge clk);
      #1;
   end
   endtask
   task check(input [8*8-1:0] what, input [35:0] seen, input [35:0] exp);
   begin
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
         err_count = err_count + 1;
         $display("BAD %0s expected %h seen %h", what, exp, seen);
      end
   end
   endtask
   task complete_run;
   begin
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   end
   endtask
   task wait_light(input lvl);
   begin
      k = 0;
      while (backlight_power_en !== lvl && k < 100)
      begin
         tick(1);
         k = k + 1;
      end
      if (k == 100)
      begin
         err_count = err_count + 1;
         complete_run;
      end
   end
   endtask
   // Counts activity over a span; pixels are only compared while the bus is non-zero.
   task watch(input integer n);
   begin
      {n_hi, n_lo, n_lp, n_fm, n_px, n_bad, n_zc} = 0;
      lp_prev = line_latch_pulse;
      repeat (n)
      begin
         tick(1);
         n_hi = n_hi + ac_drive_or_display_enable;
         n_lo = n_lo + !ac_drive_or_display_enable;
         n_lp = n_lp + (line_latch_pulse && !lp_prev);
         lp_prev = line_latch_pulse;
         n_fm = n_fm + frame_first_line_marker;
         n_zc = n_zc + (zv_pixel_clock && !zc_prev);
         zc_prev = zv_pixel_clock;
         if (panel_shift_clock && {panel_pixel_high_group, panel_pixel_low_group} != 36'h0)
         begin
            n_px = n_px + 1;
            n_bad = n_bad + ({panel_pixel_high_group, panel_pixel_low_group} !== gfx_pixel);
         end
      end
   end
   endtask
   initial
   begin
      {clk, rst, ctrl_enable, zv_enable, zv_yuv_mode, zv_clk_half, zv_key_mode, zv_x2, zv_y2} = 9'h080;
      {power_mode, mp_mode, zc_prev, err_count, num_checks} = 0;
      {h_active, h_total, v_active, v_total} = {12'h008, 12'h010, 12'h004, 12'h006};
      gfx_pixel = 36'h987654321;
      zv_color_key = gfx_pixel[15:0];
      tick(3);
      check("enables", {panel_logic_power_en, panel_bias_power_en, backlight_power_en}, 0);
      rst = 1'b0;
      ctrl_enable = 1'b1;
      wait_light(1'b1);
      check("logic", panel_logic_power_en, 1);
      check("bias", panel_bias_power_en, 1);
      check("crt", crt_output_en, 1);
      watch(400);
      check("latch", n_lp > 8, 1);
      check("marker", n_fm > 0 && n_fm < n_lp, 1);
      check("pixels", n_px > 0, 1);
      check("pixbad", n_bad, 0);
      $display("test power up done");
      for (i = 0; i < 3; i = i + 1)
      begin
         mp_mode = i[1:0];
         watch(400);
         check("mpmode", n_hi > 0 && n_lo > 0, 1);
      end
      $display("test multipurpose pin done");
      zv_enable = 1'b1;
      zv_color_key = ~gfx_pixel[15:0];
      watch(400);
      check("nokey", n_bad, 0);
      zv_color_key = gfx_pixel[15:0];
      for (i = 0; i < 2; i = i + 1)
      begin
         {zv_key_mode, zv_yuv_mode, zv_x2, zv_y2, zv_clk_half} = {5{i[0]}};
         watch(400);
         check("overlay", n_bad > 0, 1);
         z_full = n_zc;
         zv_clk_half = !zv_clk_half;
         watch(400);
         check("zvclk", (zv_clk_half ? n_zc < z_full : n_zc > z_full), 1);
      end
      zv_enable = 1'b0;
      $display("test zoomed video done");
      for (i = 0; i < 3; i = i + 1)
      begin
         ctrl_enable = (i != 2);
         power_mode = (i == 0) ? `FPV_PM_PANEL_OFF : (i == 1) ? `FPV_PM_STANDBY : `FPV_PM_ON;
         wait_light(1'b0);
         tick(20);
         check("pwr", {panel_logic_power_en, panel_bias_power_en, crt_output_en}, 0);
         check("quiet", {panel_shift_clock, panel_pixel_low_group}, 0);
         check("gfxrun", graphics_run, i == 0);
         check("refresh", dram_self_refresh, i != 0);
         {ctrl_enable, power_mode} = {1'b1, `FPV_PM_ON};
         wait_light(1'b1);
      end
      $display("test power modes done");
      rst = 1'b1;
      tick(2);
      check("reset", {panel_logic_power_en, backlight_power_en, panel_shift_clock}, 0);
      $display("test second reset done");
      complete_run;
   end
endmodule
